/* File: hdl/mup_pkg.sv */
// Package of constants and types for the parallel host pixel unpacker.
package mup_pkg;

	// Interface mode strap codes.
	localparam logic [3:0] MUP_IM_T1_16 = 4'h1;
	localparam logic [3:0] MUP_IM_T1_18 = 4'h3;
	localparam logic [3:0] MUP_IM_T2_16 = 4'h8;
	localparam logic [3:0] MUP_IM_T2_18 = 4'hA;

	// Host pixel format codes.
	localparam logic [2:0] MUP_FMT_65K  = 3'h5;
	localparam logic [2:0] MUP_FMT_262K = 3'h6;

	// Split transfer modes for 262K colours on a 16-bit bus.
	localparam logic [1:0] MUP_SPLIT_00 = 2'h0;
	localparam logic [1:0] MUP_SPLIT_01 = 2'h1;
	localparam logic [1:0] MUP_SPLIT_10 = 2'h2;
	localparam logic [1:0] MUP_SPLIT_11 = 2'h3;

	// APB register byte addresses.
	localparam logic [7:0] MUP_CTRL_ADDR   = 8'h00;
	localparam logic [7:0] MUP_STATUS_ADDR = 8'h04;
	localparam logic [7:0] MUP_CMD_ADDR    = 8'h08;
	localparam logic [7:0] MUP_PIXCNT_ADDR = 8'h0C;

	// Control register fields and reset values.
	localparam int         MUP_CTRL_FMT_LSB   = 0;
	localparam int         MUP_CTRL_SPLIT_LSB = 4;
	localparam logic [2:0] MUP_FMT_RST        = 3'h6;
	localparam logic [1:0] MUP_SPLIT_RST      = 2'h0;

	// Status register fields.
	localparam int MUP_STAT_IM_LSB    = 0;
	localparam int MUP_STAT_SUPP_BIT  = 4;
	localparam int MUP_STAT_VALID_BIT = 5;
	localparam int MUP_STAT_PHASE_LSB = 8;

	// Edges after reset release before the synchronised strap is trusted.
	localparam logic [1:0] MUP_STRAP_WAIT = 2'h3;

	// Idle level of the synchronised pins: write strobe high, rest low.
	localparam logic [23:0] MUP_PIN_IDLE = 24'h800000;

	typedef enum logic [2:0] {
		MUP_PH0 = 3'b001,
		MUP_PH1 = 3'b010,
		MUP_PH2 = 3'b100
	} mup_phase_t;

	typedef struct packed {
		logic        wr_n;
		logic        dc;
		logic [17:0] data;
		logic [3:0]  im;
	} mup_pins_t;

	typedef struct packed {
		logic [5:0] r;
		logic [5:0] g;
		logic [5:0] b;
	} mup_pixel_t;

endpackage

/* File: hdl/mup_sync2.sv */
// Two-stage synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module mup_sync2 #(
	parameter int              WIDTH   = 24,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// The first stage feeds only the second stage.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;

endmodule // mup_sync2
`default_nettype wire

/* File: hdl/mup_unpacker.sv */
// Parallel host pixel unpacker with APB control and status registers.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Strap 1000 selects type-II 16-bit parallel host mode.
// - Strap 0011 selects type-I 18-bit parallel host mode.
// - Format 101 takes one whole pixel per transfer on 16 or 18 bits.
// - Format 110 on 16 bits builds each pixel from several transfers.
// - Format 110 on the 18-bit bus takes one pixel per transfer.
// - Select line low marks a command, high marks pixel data.
// - Split 00: two components per word, three words give two pixels.
// - Split 01: red and green first, blue in the second high byte.
// - Split 10: RGB packed first, blue bits 1:0 in second word top.
// - Split 11: red 5:4 in low bits, then red 3:0, green, blue.
// - Host interface type comes from strap pins, not from software.
// - Strap 0001 selects type-I 16-bit parallel host mode.
module mup_unpacker
	import mup_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        host_wr_n,
	input  wire logic        cmd_data_select,
	input  wire logic [17:0] host_data,
	input  wire logic [3:0]  interface_mode_pins,
	output logic             pix_valid,
	output logic      [17:0] pix_data,
	output logic             cmd_valid,
	output logic      [7:0]  cmd_byte
);

	typedef struct packed {
		logic [2:0]  fmt;
		logic [1:0]  split;
		logic [3:0]  im;
		logic [1:0]  strap_cnt;
		logic        im_valid;
		logic        prev_wr;
		mup_phase_t  phase;
		mup_pixel_t  part;
		logic [5:0]  r1;
		logic        pix_valid;
		mup_pixel_t  pix;
		logic        cmd_valid;
		logic [7:0]  cmd;
		logic [15:0] pix_cnt;
		logic [31:0] prdata;
		logic        pslverr;
	} mup_state_t;

	localparam mup_state_t ST_RST = '{
		fmt: MUP_FMT_RST, split: MUP_SPLIT_RST, im: 4'h0, strap_cnt: 2'h0,
		im_valid: 1'b0, prev_wr: 1'b1, phase: MUP_PH0, part: 18'h00000,
		r1: 6'h00, pix_valid: 1'b0, pix: 18'h00000, cmd_valid: 1'b0,
		cmd: 8'h00, pix_cnt: 16'h0000, prdata: 32'h00000000, pslverr: 1'b0};

	mup_state_t st_ff;
	mup_state_t nxt_st;
	mup_pins_t  pins_raw;
	mup_pins_t  pins_s;

	logic        supported;
	logic        bus18;
	logic        type2;
	logic        wr_evt;
	logic        cmd_evt;
	logic        dat_evt;
	logic [15:0] word16;
	logic [7:0]  cmd_lanes;
	logic        setup;
	logic        acc_wr;

	assign pins_raw = '{wr_n: host_wr_n, dc: cmd_data_select,
		data: host_data, im: interface_mode_pins};

	// Every pin is asynchronous to pclk, so all of them are synchronised.
	mup_sync2 #(
		.WIDTH   (24),
		.RST_VAL (MUP_PIN_IDLE)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (pins_raw),
		.q       (pins_s)
	);

	// Mode decode from the captured strap.
	always_comb begin
		supported = st_ff.im_valid && (st_ff.im == MUP_IM_T1_16 || st_ff.im == MUP_IM_T2_16 ||
			st_ff.im == MUP_IM_T1_18 || st_ff.im == MUP_IM_T2_18);
		bus18 = (st_ff.im == MUP_IM_T1_18) || (st_ff.im == MUP_IM_T2_18);
		type2 = (st_ff.im == MUP_IM_T2_16) || (st_ff.im == MUP_IM_T2_18);
	end

	// Lane mapping of the two bus variants.
	always_comb begin
		if (st_ff.im == MUP_IM_T2_16) begin
			word16 = {pins_s.data[17:10], pins_s.data[8:1]};
		end else begin
			word16 = pins_s.data[15:0];
		end
		if (type2) begin
			cmd_lanes = pins_s.data[8:1];
		end else begin
			cmd_lanes = pins_s.data[7:0];
		end
	end

	// A transfer is taken on the rising edge of the synchronised strobe.
	assign wr_evt  = supported && !st_ff.prev_wr && pins_s.wr_n;
	assign cmd_evt = wr_evt && !pins_s.dc;
	assign dat_evt = wr_evt && pins_s.dc;
	assign setup   = psel && !penable;
	assign acc_wr  = psel && penable && pwrite;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.pix_valid = 1'b0;
		nxt_st.cmd_valid = 1'b0;
		nxt_st.prev_wr = pins_s.wr_n;

		// The strap is caught once the synchroniser has filled after reset.
		if (!st_ff.im_valid) begin
			if (st_ff.strap_cnt == MUP_STRAP_WAIT) begin
				nxt_st.im = pins_s.im;
				nxt_st.im_valid = 1'b1;
			end else begin
				nxt_st.strap_cnt = st_ff.strap_cnt + 2'h1;
			end
		end

		if (cmd_evt) begin
			nxt_st.cmd = cmd_lanes;
			nxt_st.cmd_valid = 1'b1;
			nxt_st.phase = MUP_PH0;
		end else if (dat_evt) begin
			if (st_ff.fmt == MUP_FMT_65K) begin
				nxt_st.pix.r = {word16[15:11], word16[15]};
				nxt_st.pix.g = word16[10:5];
				nxt_st.pix.b = {word16[4:0], word16[4]};
				nxt_st.pix_valid = 1'b1;
			end else if (st_ff.fmt == MUP_FMT_262K && bus18) begin
				nxt_st.pix = pins_s.data;
				nxt_st.pix_valid = 1'b1;
			end else if (st_ff.fmt == MUP_FMT_262K) begin
				unique case (st_ff.split)
					MUP_SPLIT_00: begin
						unique case (st_ff.phase)
							MUP_PH0: begin
								nxt_st.part.r = word16[15:10];
								nxt_st.part.g = word16[7:2];
								nxt_st.phase = MUP_PH1;
							end
							MUP_PH1: begin
								nxt_st.pix = {st_ff.part.r, st_ff.part.g, word16[15:10]};
								nxt_st.pix_valid = 1'b1;
								nxt_st.r1 = word16[7:2];
								nxt_st.phase = MUP_PH2;
							end
							MUP_PH2: begin
								nxt_st.pix = {st_ff.r1, word16[15:10], word16[7:2]};
								nxt_st.pix_valid = 1'b1;
								nxt_st.phase = MUP_PH0;
							end
							default: nxt_st.phase = MUP_PH0;
						endcase
					end
					MUP_SPLIT_01: begin
						if (st_ff.phase == MUP_PH0) begin
							nxt_st.part.r = word16[15:10];
							nxt_st.part.g = word16[7:2];
							nxt_st.phase = MUP_PH1;
						end else begin
							// The low byte of the second word carries nothing.
							nxt_st.pix = {st_ff.part.r, st_ff.part.g, word16[15:10]};
							nxt_st.pix_valid = 1'b1;
							nxt_st.phase = MUP_PH0;
						end
					end
					MUP_SPLIT_10: begin
						if (st_ff.phase == MUP_PH0) begin
							nxt_st.part = {word16[15:0], 2'b00};
							nxt_st.phase = MUP_PH1;
						end else begin
							nxt_st.pix = {st_ff.part[17:2], word16[15:14]};
							nxt_st.pix_valid = 1'b1;
							nxt_st.phase = MUP_PH0;
						end
					end
					MUP_SPLIT_11: begin
						if (st_ff.phase == MUP_PH0) begin
							nxt_st.part = {word16[1:0], 16'h0000};
							nxt_st.phase = MUP_PH1;
						end else begin
							nxt_st.pix = {st_ff.part[17:16], word16};
							nxt_st.pix_valid = 1'b1;
							nxt_st.phase = MUP_PH0;
						end
					end
				endcase
			end
		end

		if (nxt_st.pix_valid) begin
			nxt_st.pix_cnt = st_ff.pix_cnt + 16'h0001;
		end

		// Register writes land in the access phase; read data is built in setup.
		if (acc_wr && paddr == MUP_CTRL_ADDR) begin
			if (pstrb[0]) begin
				nxt_st.fmt = pwdata[MUP_CTRL_FMT_LSB +: 3];
				nxt_st.split = pwdata[MUP_CTRL_SPLIT_LSB +: 2];
			end
		end
		if (acc_wr && paddr == MUP_PIXCNT_ADDR && pstrb[0]) begin
			nxt_st.pix_cnt = 16'h0000;
		end
		if (setup) begin
			nxt_st.prdata = 32'h00000000;
			nxt_st.pslverr = 1'b0;
			unique case (paddr)
				MUP_CTRL_ADDR: begin
					nxt_st.prdata[MUP_CTRL_FMT_LSB +: 3] = st_ff.fmt;
					nxt_st.prdata[MUP_CTRL_SPLIT_LSB +: 2] = st_ff.split;
				end
				MUP_STATUS_ADDR: begin
					nxt_st.prdata[MUP_STAT_IM_LSB +: 4] = st_ff.im;
					nxt_st.prdata[MUP_STAT_SUPP_BIT] = supported;
					nxt_st.prdata[MUP_STAT_VALID_BIT] = st_ff.im_valid;
					nxt_st.prdata[MUP_STAT_PHASE_LSB +: 3] = st_ff.phase;
				end
				MUP_CMD_ADDR: nxt_st.prdata[7:0] = st_ff.cmd;
				MUP_PIXCNT_ADDR: nxt_st.prdata[15:0] = st_ff.pix_cnt;
				default: nxt_st.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= ST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Zero wait states: data was prepared in the setup cycle.
	assign pready    = 1'b1;
	assign prdata    = st_ff.prdata;
	assign pslverr   = st_ff.pslverr;
	assign pix_valid = st_ff.pix_valid;
	assign pix_data  = st_ff.pix;
	assign cmd_valid = st_ff.cmd_valid;
	assign cmd_byte  = st_ff.cmd;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	strap_type2_a: assert property (st_ff.im_valid && st_ff.im == MUP_IM_T2_16 && cmd_evt
		|=> cmd_valid && cmd_byte == $past(pins_s.data[8:1]))
		else $error("type-II command not taken from lines 8 to 1");
	cmd_type1_a: assert property (cmd_evt && !type2
		|=> cmd_valid && cmd_byte == $past(pins_s.data[7:0]) && !pix_valid)
		else $error("type-I command byte wrong");
	cmd_restart_a: assert property (cmd_evt |=> st_ff.phase == MUP_PH0)
		else $error("command did not restart split sequencing");
	pix65_map_a: assert property (dat_evt && st_ff.fmt == MUP_FMT_65K
		|=> pix_valid && pix_data[17:12] == {$past(word16[15:11]), $past(word16[15])}
		&& pix_data[11:6] == $past(word16[10:5]))
		else $error("65K pixel mapping wrong");
	pix18_full_a: assert property (dat_evt && st_ff.fmt == MUP_FMT_262K && bus18
		|=> pix_valid && pix_data == $past(pins_s.data))
		else $error("18-bit pixel not taken whole");
	split01_blue_a: assert property (dat_evt && st_ff.fmt == MUP_FMT_262K && !bus18
		&& st_ff.split == MUP_SPLIT_01 && st_ff.phase == MUP_PH1
		|=> pix_valid && pix_data[5:0] == $past(word16[15:10]))
		else $error("split 01 blue wrong");
	split10_low_a: assert property (dat_evt && st_ff.fmt == MUP_FMT_262K && !bus18
		&& st_ff.split == MUP_SPLIT_10 && st_ff.phase == MUP_PH1
		|=> pix_valid && pix_data[1:0] == $past(word16[15:14]))
		else $error("split 10 blue low bits wrong");
	split11_word_a: assert property (dat_evt && st_ff.fmt == MUP_FMT_262K && !bus18
		&& st_ff.split == MUP_SPLIT_11 && st_ff.phase == MUP_PH1
		|=> pix_valid && pix_data[15:0] == $past(word16))
		else $error("split 11 second word wrong");
	split00_pair_a: assert property (dat_evt && st_ff.fmt == MUP_FMT_262K && !bus18
		&& st_ff.split == MUP_SPLIT_00 && st_ff.phase == MUP_PH2
		|=> pix_valid && pix_data[11:0] == {$past(word16[15:10]), $past(word16[7:2])})
		else $error("split 00 second pixel wrong");
	split_first_a: assert property (dat_evt && st_ff.fmt == MUP_FMT_262K && !bus18
		&& st_ff.phase == MUP_PH0 |=> !pix_valid)
		else $error("pixel emitted on first split transfer");
	pix_pulse_a: assert property (pix_valid |=> !pix_valid ##1 !pix_valid)
		else $error("pixel strobe longer than one cycle");

	cov_split00_c: cover property (st_ff.split == MUP_SPLIT_00 && pix_valid ##[1:100] pix_valid);
	cov_cmd_then_pix_c: cover property (cmd_valid ##[1:100] pix_valid);
	cov_fmt65_c: cover property (st_ff.fmt == MUP_FMT_65K && pix_valid);

endmodule // mup_unpacker
`default_nettype wire

/* File: tb/mup_host_model.sv */
// Host microcontroller model that drives the parallel write bus and the mode straps.
`timescale 1ns/1ps
`default_nettype none
module mup_host_model
	import mup_pkg::*;
(
	input  wire logic        pclk,
	output logic             wr_n,
	output logic             dc,
	output logic      [17:0] data,
	output logic      [3:0]  im
);
	initial begin
		wr_n = 1'b1;
		dc   = 1'b1;
		data = 18'h0;
		im   = MUP_IM_T1_16;
	end

	// The strap only changes while the device is held in reset.
	task automatic strap(input logic [3:0] s);
		im <= s;
	endtask

	// Strobe low four cycles then high eight, lines held four cycles past the rising strobe.
	task automatic send(input logic sel, input logic [17:0] d);
		@(posedge pclk);
		dc   <= sel;
		data <= d;
		wr_n <= 1'b0;
		repeat (4) @(posedge pclk);
		wr_n <= 1'b1;
		repeat (4) @(posedge pclk);
		// Released lines show the inverse so that a late sample is caught.
		data <= ~d;
		dc   <= ~sel;
		repeat (4) @(posedge pclk);
	endtask
endmodule // mup_host_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking testbench of the parallel host pixel unpacker.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import mup_pkg::*;
;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	wire         wr_n;
	wire         dc;
	wire  [17:0] hd;
	wire  [3:0]  im;
	logic        pix_valid;
	logic [17:0] pix_data;
	logic        cmd_valid;
	logic [7:0]  cmd_byte;
	logic [31:0] rd;
	logic        er;
	logic [3:0]  strap_ff;
	logic [17:0] pq[$];
	logic [7:0]  cq[$];
	int          comparisons = 0;
	int          miscompares = 0;
	localparam logic [5:0] R = 6'h2D, G = 6'h1A, B = 6'h33, R1 = 6'h0E, G1 = 6'h35, B1 = 6'h21;
	localparam logic [15:0] W65 = {5'h13, 6'h2A, 5'h0C};
	localparam logic [17:0] P65 = {6'h27, 6'h2A, 6'h18};

	mup_unpacker uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.host_wr_n(wr_n), .cmd_data_select(dc), .host_data(hd), .interface_mode_pins(im),
		.pix_valid(pix_valid), .pix_data(pix_data), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte));
	mup_host_model host (.pclk(pclk), .wr_n(wr_n), .dc(dc), .data(hd), .im(im));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (pix_valid === 1'b1) pq.push_back(pix_data);
		if (cmd_valid === 1'b1) cq.push_back(cmd_byte);
	end

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	// The wait for pready has no limit of its own; only the watchdog ends a hung transfer.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rst(input logic [3:0] s);
		strap_ff = s;
		host.strap(s);
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(1'b0, MUP_STATUS_ADDR, 32'h0);
		chk("status", rd, {21'h0, 3'b001, 2'b00, 1'b1, 1'b1, s});
	endtask

	function automatic logic [17:0] map16(input logic [15:0] w);
		return (strap_ff == MUP_IM_T2_16) ? {w[15:8], 1'b1, w[7:0], 1'b1} : {2'b11, w};
	endfunction

	task automatic cfg(input logic [2:0] f, input logic [1:0] sp);
		apb(1'b1, MUP_CTRL_ADDR, {26'h0, sp, 1'b0, f});
	endtask

	task automatic w16(input logic [15:0] w);
		host.send(1'b1, map16(w));
	endtask

	task automatic cmd(input logic [7:0] c);
		host.send(1'b0, map16({8'hA5, c}));
		chk("command", (cq.size() > 0) ? {24'h0, cq.pop_front()} : 32'hFFFFFFFF, {24'h0, c});
	endtask

	task automatic pix(input logic [17:0] e);
		chk("pixel", (pq.size() > 0) ? {14'h0, pq.pop_front()} : 32'hFFFFFFFF, {14'h0, e});
	endtask

	task automatic none();
		chk("pixel queue", 32'(pq.size()), 32'h0);
	endtask

	task automatic t_regs();
		apb(1'b0, MUP_CTRL_ADDR, 32'h0);
		chk("ctrl reset", rd, 32'h00000006);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped err", {31'h0, er}, 32'h1);
		chk("unmapped data", rd, 32'h0);
	endtask

	task automatic t_type1_16();
		rst(MUP_IM_T1_16);
		cmd(8'h2C);
		cfg(MUP_FMT_65K, MUP_SPLIT_00);
		w16(W65);
		pix(P65);
		cfg(MUP_FMT_262K, MUP_SPLIT_00);
		w16({R, 2'b11, G, 2'b11});
		none();
		w16({B, 2'b11, R1, 2'b11});
		pix({R, G, B});
		w16({G1, 2'b11, B1, 2'b11});
		pix({R1, G1, B1});
		cfg(MUP_FMT_262K, MUP_SPLIT_01);
		w16({R1, 2'b11, G1, 2'b11});
		cmd(8'h2C);
		w16({R, 2'b11, G, 2'b11});
		w16({B, 10'h3FF});
		pix({R, G, B});
		cfg(MUP_FMT_262K, MUP_SPLIT_10);
		w16({R, G, B[5:2]});
		w16({B[1:0], 14'h3FFF});
		pix({R, G, B});
		cfg(MUP_FMT_262K, MUP_SPLIT_11);
		w16({14'h3FFF, R1[5:4]});
		w16({R1[3:0], G1, B1});
		pix({R1, G1, B1});
		none();
		apb(1'b0, MUP_CMD_ADDR, 32'h0);
		chk("command register", rd, 32'h0000002C);
		apb(1'b0, MUP_PIXCNT_ADDR, 32'h0);
		chk("pixel count", rd, 32'h00000006);
		apb(1'b1, MUP_PIXCNT_ADDR, 32'h0);
		apb(1'b0, MUP_PIXCNT_ADDR, 32'h0);
		chk("pixel count clear", rd, 32'h0);
	endtask

	task automatic t_type2_16();
		rst(MUP_IM_T2_16);
		cmd(8'h3A);
		cfg(MUP_FMT_65K, MUP_SPLIT_00);
		w16(W65);
		pix(P65);
		cfg(MUP_FMT_262K, MUP_SPLIT_10);
		w16({R1, G1, B1[5:2]});
		w16({B1[1:0], 14'h3FFF});
		pix({R1, G1, B1});
		none();
	endtask

	task automatic t_type1_18();
		rst(MUP_IM_T1_18);
		cmd(8'h2C);
		cfg(MUP_FMT_262K, MUP_SPLIT_00);
		host.send(1'b1, {R, G, B});
		pix({R, G, B});
		cfg(MUP_FMT_65K, MUP_SPLIT_00);
		host.send(1'b1, {2'b11, W65});
		pix(P65);
		none();
	endtask

	// The type-II 18-bit bus takes its command on lines 8 to 1 and a whole pixel per word.
	task automatic t_type2_18();
		rst(MUP_IM_T2_18);
		host.send(1'b0, {9'h1FF, 8'h5C, 1'b1});
		chk("command", (cq.size() > 0) ? {24'h0, cq.pop_front()} : 32'hFFFFFFFF, 32'h0000005C);
		host.send(1'b1, {G1, B1, R1});
		pix({G1, B1, R1});
		none();
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// The whole sequence needs about five hundred cycles; this limit leaves ample margin.
	initial begin
		#100us;
		miscompares++;
		report_and_stop();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		strap_ff = MUP_IM_T1_16;
		rst(MUP_IM_T1_16);
		t_regs();
		t_type1_16();
		t_type2_16();
		t_type1_18();
		t_type2_18();
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
